// ### include/adccr_cfg.svh
// constants for the converter control register block: layout, reset values and access timing
`ifndef ADCCR_CFG_SVH
`define ADCCR_CFG_SVH

// control word layout
`define ADCCR_WORD_W 12
`define ADCCR_FIELD_W 10
`define ADCCR_SEL_HI 11
`define ADCCR_SEL_LO 10
`define ADCCR_SEL_CTRL0 2'h0
`define ADCCR_SEL_CTRL1 2'h1

// second control register fields
`define ADCCR_B_RESET 0
`define ADCCR_B_SYNC 1
`define ADCCR_RSV_HI 5
`define ADCCR_RSV_LO 2
`define ADCCR_B_RW 6
`define ADCCR_B_FMT 7
`define ADCCR_B_OFFS 8
`define ADCCR_B_DBG 9

// reset values of both control registers
`define ADCCR_CTRL0_RST 10'h020
`define ADCCR_CTRL1_RST 10'h030

// host strobe timing
`define ADCCR_STROBE_NS 30
`define ADCCR_HOLD_NS 10
`define ADCCR_CLK_NS 10
`define ADCCR_STROBE_CYC ((`ADCCR_STROBE_NS + `ADCCR_CLK_NS - 1) / `ADCCR_CLK_NS)
`define ADCCR_HOLD_CYC ((`ADCCR_HOLD_NS + `ADCCR_CLK_NS - 1) / `ADCCR_CLK_NS)

// host register map, byte addresses
`define ADCCR_A_CTRL1 8'h00
`define ADCCR_A_CTRL0 8'h04
`define ADCCR_A_READ 8'h08
`define ADCCR_A_STAT 8'h0C
`define ADCCR_A_RDATA 8'h10

`define ADCCR_RESP_OKAY 2'h0
`define ADCCR_RESP_SLVERR 2'h2

`endif

// ### include/adccr_pkg.sv
// types shared by both ends of the converter control port
package adccr_pkg;
	typedef logic [11:0] adccr_word_t;
	typedef logic [9:0] adccr_field_t;
	typedef enum logic [1:0] {ADCCR_H_IDLE, ADCCR_H_STROBE, ADCCR_H_HOLD} adccr_hstate_e;
endpackage

// ### include/adccr_if.sv
// parallel strobe port between the converter and its controlling processor
`timescale 1ns/1ps
interface adccr_if;
	logic cs0_n;
	logic cs1;
	logic wr_n;
	logic rd_n;
	logic [11:0] host_d;
	logic host_d_oe;
	logic [11:0] dev_d;
	logic dev_d_oe;
	logic [11:0] d;

	// wire level of the shared data bus, worked out from both enables
	assign d = dev_d_oe ? dev_d : (host_d_oe ? host_d : 12'h000);

	modport dev (input cs0_n, input cs1, input wr_n, input rd_n, input d, output dev_d, output dev_d_oe);
	modport host (output cs0_n, output cs1, output wr_n, output rd_n, output host_d, output host_d_oe, input d);
endinterface

// ### verilog/adccr_dev.sv
// converter end: both control registers, strobe decode, offset calibration and result formatting
`timescale 1ns/1ps
`include "adccr_cfg.svh"

module adccr_dev
	import adccr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	adccr_if.dev bus,
	input wire logic sample_valid,
	input wire logic [11:0] sample_code,
	output logic cal_force_zero,
	output logic [11:0] result,
	output logic result_valid,
	output logic sync_gen_reset,
	output logic [9:0] ctrl0_q,
	output logic [9:0] ctrl1_q
);

	////////////////////////////////////////////////////////////////////////
	// strobe decode

	adccr_field_t ctrl1_r, ctrl1_nxt;
	logic sel;
	logic rd_act;
	logic wr_act;
	logic combined;

	assign combined = ctrl1_r[`ADCCR_B_RW];
	assign sel = !bus.cs0_n && bus.cs1;
	always_comb
	begin
		if (combined)
		begin
			rd_act = sel && bus.wr_n;
			wr_act = sel && !bus.wr_n;
		end
		else
		begin
			rd_act = sel && !bus.rd_n && bus.wr_n;
			wr_act = sel && !bus.wr_n && bus.rd_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers and access tracking

	adccr_field_t ctrl0_r, ctrl0_nxt;
	adccr_word_t wlat_r, wlat_nxt;
	logic wr_prev_r, wr_prev_nxt;
	logic rd_prev_r, rd_prev_nxt;
	logic [1:0] dbg_cnt_r, dbg_cnt_nxt;
	logic sync_r, sync_nxt;
	logic cal_r, cal_nxt;
	logic commit;
	logic rd_start;
	logic in_reset;

	assign commit = wr_prev_r && !wr_act;
	assign rd_start = rd_act && !rd_prev_r;
	assign in_reset = ctrl1_r[`ADCCR_B_RESET];

	// register select carried in the two upper bits of a latched word
	function automatic logic sel_is(input adccr_word_t w, input logic [1:0] s);
		return w[`ADCCR_SEL_HI:`ADCCR_SEL_LO] == s;
	endfunction

	always_comb
	begin
		ctrl0_nxt = ctrl0_r;
		ctrl1_nxt = ctrl1_r;
		wlat_nxt = wr_act ? bus.d : wlat_r;
		wr_prev_nxt = wr_act;
		rd_prev_nxt = rd_act;
		dbg_cnt_nxt = dbg_cnt_r;
		sync_nxt = 1'b0;
		cal_nxt = cal_r;
		// clear first, so a new calibration request in the same cycle still wins
		if (cal_r && sample_valid)
			cal_nxt = 1'b0;
		// debug reads step through register zero, then register one, then results
		if (rd_start && ctrl1_r[`ADCCR_B_DBG] && dbg_cnt_r != 2'h2)
			dbg_cnt_nxt = dbg_cnt_r + 2'h1;
		if (commit && sel_is(wlat_r, `ADCCR_SEL_CTRL1))
		begin
			if (wlat_r[`ADCCR_B_RESET])
			begin
				// the reset bit itself stays set so the device holds in reset
				ctrl0_nxt = `ADCCR_CTRL0_RST;
				ctrl1_nxt = `ADCCR_CTRL1_RST | 10'h001;
				cal_nxt = 1'b0;
			end
			else
			begin
				ctrl1_nxt = wlat_r[`ADCCR_FIELD_W-1:0];
				sync_nxt = wlat_r[`ADCCR_B_SYNC];
				if (wlat_r[`ADCCR_B_OFFS])
					cal_nxt = 1'b1;
				if (wlat_r[`ADCCR_B_DBG])
					dbg_cnt_nxt = 2'h0;
			end
		end
		else if (commit && !in_reset && sel_is(wlat_r, `ADCCR_SEL_CTRL0))
			ctrl0_nxt = wlat_r[`ADCCR_FIELD_W-1:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl0_r <= `ADCCR_CTRL0_RST;
			ctrl1_r <= `ADCCR_CTRL1_RST;
			wlat_r <= 12'h000;
			wr_prev_r <= 1'b0;
			rd_prev_r <= 1'b0;
			dbg_cnt_r <= 2'h2;
			sync_r <= 1'b0;
			cal_r <= 1'b0;
		end
		else
		begin
			ctrl0_r <= ctrl0_nxt;
			ctrl1_r <= ctrl1_nxt;
			wlat_r <= wlat_nxt;
			wr_prev_r <= wr_prev_nxt;
			rd_prev_r <= rd_prev_nxt;
			dbg_cnt_r <= dbg_cnt_nxt;
			sync_r <= sync_nxt;
			cal_r <= cal_nxt;
		end
	end

	assign ctrl0_q = ctrl0_r;
	assign ctrl1_q = ctrl1_r;
	assign sync_gen_reset = sync_r;
	assign cal_force_zero = cal_r;

	////////////////////////////////////////////////////////////////////////
	// conversion path

	adccr_word_t offs_r, offs_nxt;
	adccr_word_t res_r, res_nxt;
	logic resv_r, resv_nxt;
	adccr_word_t diff;

	assign diff = sample_code - offs_r;

	always_comb
	begin
		offs_nxt = offs_r;
		res_nxt = res_r;
		resv_nxt = 1'b0;
		if (commit && sel_is(wlat_r, `ADCCR_SEL_CTRL1) && wlat_r[`ADCCR_B_RESET])
			offs_nxt = 12'h000;
		else if (sample_valid && cal_r)
			offs_nxt = sample_code;
		else if (sample_valid && !in_reset)
		begin
			// binary output is the twos complement value with its sign bit flipped
			if (ctrl1_r[`ADCCR_B_FMT])
				res_nxt = {~diff[11], diff[10:0]};
			else
				res_nxt = diff;
			resv_nxt = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			offs_r <= 12'h000;
			res_r <= 12'h000;
			resv_r <= 1'b0;
		end
		else
		begin
			offs_r <= offs_nxt;
			res_r <= res_nxt;
			resv_r <= resv_nxt;
		end
	end

	assign result = res_r;
	assign result_valid = resv_r;

	////////////////////////////////////////////////////////////////////////
	// read data drive

	adccr_word_t dout_r, dout_nxt;
	logic doe_r, doe_nxt;

	always_comb
	begin
		doe_nxt = rd_act;
		dout_nxt = dout_r;
		if (rd_start)
		begin
			if (ctrl1_r[`ADCCR_B_DBG] && dbg_cnt_r == 2'h0)
				dout_nxt = {`ADCCR_SEL_CTRL0, ctrl0_r};
			else if (ctrl1_r[`ADCCR_B_DBG] && dbg_cnt_r == 2'h1)
				dout_nxt = {`ADCCR_SEL_CTRL1, ctrl1_r};
			else
				dout_nxt = res_r;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dout_r <= 12'h000;
			doe_r <= 1'b0;
		end
		else
		begin
			dout_r <= dout_nxt;
			doe_r <= doe_nxt;
		end
	end

	assign bus.dev_d = dout_r;
	assign bus.dev_d_oe = doe_r;

endmodule

// ### verilog/adccr_host.sv
// processor end: AXI4-Lite command registers driving the parallel strobe port
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "adccr_cfg.svh"

module adccr_host
	import adccr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	adccr_if.host bus,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	logic [7:0] awa_r, awa_nxt;
	logic awh_r, awh_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic wh_r, wh_nxt;
	logic bv_r, bv_nxt;
	logic [1:0] br_r, br_nxt;
	logic rv_r, rv_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic [1:0] rr_r, rr_nxt;
	adccr_hstate_e st_r, st_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic is_rd_r, is_rd_nxt;
	adccr_word_t word_r, word_nxt;
	adccr_word_t rdat_r, rdat_nxt;
	logic mode_r, mode_nxt;
	logic [1:0] ws_r, ws_nxt;
	logic awrdy_r, wrdy_r, ardy_r;
	logic do_wr;
	logic go;

	assign do_wr = awh_r && wh_r && !bv_r;
	// strobes are only valid with wvalid, so the ones taken with the data decide
	assign go = do_wr && st_r == ADCCR_H_IDLE && ws_r == 2'h3;

	always_comb
	begin
		awa_nxt = awa_r;
		awh_nxt = awh_r;
		wd_nxt = wd_r;
		wh_nxt = wh_r;
		bv_nxt = bv_r && !s_axi_bready;
		br_nxt = br_r;
		rv_nxt = rv_r && !s_axi_rready;
		rd_nxt = rd_r;
		rr_nxt = rr_r;
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		is_rd_nxt = is_rd_r;
		word_nxt = word_r;
		rdat_nxt = rdat_r;
		mode_nxt = mode_r;
		ws_nxt = ws_r;
		if (s_axi_awvalid && !awh_r)
		begin
			awa_nxt = s_axi_awaddr;
			awh_nxt = 1'b1;
		end
		if (s_axi_wvalid && !wh_r)
		begin
			wd_nxt = s_axi_wdata;
			ws_nxt = s_axi_wstrb[1:0];
			wh_nxt = 1'b1;
		end
		if (do_wr)
		begin
			awh_nxt = 1'b0;
			wh_nxt = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = `ADCCR_RESP_OKAY;
			// a command arriving while an access runs is dropped; software polls busy first
			case (awa_r)
				`ADCCR_A_CTRL1:
				begin
					if (go)
					begin
						// reserved field forced to zero, sync and debug bits pass as given
						word_nxt = {`ADCCR_SEL_CTRL1, wd_r[9:6], 4'h0, wd_r[1:0]};
						is_rd_nxt = 1'b0;
						st_nxt = ADCCR_H_STROBE;
					end
				end
				`ADCCR_A_CTRL0:
				begin
					if (go)
					begin
						word_nxt = {`ADCCR_SEL_CTRL0, wd_r[9:0]};
						is_rd_nxt = 1'b0;
						st_nxt = ADCCR_H_STROBE;
					end
				end
				`ADCCR_A_READ:
				begin
					if (st_r == ADCCR_H_IDLE)
					begin
						is_rd_nxt = 1'b1;
						st_nxt = ADCCR_H_STROBE;
					end
				end
				default: br_nxt = `ADCCR_RESP_SLVERR;
			endcase
			cnt_nxt = 3'(`ADCCR_STROBE_CYC - 1);
		end
		case (st_r)
			ADCCR_H_STROBE:
			begin
				if (cnt_r == 3'h0)
				begin
					if (is_rd_r)
						rdat_nxt = bus.d;
					else if (word_r[`ADCCR_SEL_HI:`ADCCR_SEL_LO] == `ADCCR_SEL_CTRL1)
						mode_nxt = word_r[`ADCCR_B_RESET] ? 1'b0 : word_r[`ADCCR_B_RW];
					cnt_nxt = 3'(`ADCCR_HOLD_CYC - 1);
					st_nxt = ADCCR_H_HOLD;
				end
				else
					cnt_nxt = cnt_r - 3'h1;
			end
			ADCCR_H_HOLD:
			begin
				if (cnt_r == 3'h0)
					st_nxt = ADCCR_H_IDLE;
				else
					cnt_nxt = cnt_r - 3'h1;
			end
			default: ;
		endcase
		if (s_axi_arvalid && !rv_r)
		begin
			rv_nxt = 1'b1;
			rr_nxt = `ADCCR_RESP_OKAY;
			case (s_axi_araddr)
				`ADCCR_A_STAT: rd_nxt = {30'h0, mode_r, st_r != ADCCR_H_IDLE};
				`ADCCR_A_RDATA: rd_nxt = {20'h0, rdat_r};
				`ADCCR_A_CTRL1, `ADCCR_A_CTRL0, `ADCCR_A_READ: rd_nxt = 32'h0;
				default:
				begin
					rd_nxt = 32'h0;
					rr_nxt = `ADCCR_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awa_r <= 8'h00;
			awh_r <= 1'b0;
			wd_r <= 32'h0;
			wh_r <= 1'b0;
			bv_r <= 1'b0;
			br_r <= 2'h0;
			rv_r <= 1'b0;
			rd_r <= 32'h0;
			rr_r <= 2'h0;
			st_r <= ADCCR_H_IDLE;
			cnt_r <= 3'h0;
			is_rd_r <= 1'b0;
			word_r <= 12'h000;
			rdat_r <= 12'h000;
			mode_r <= 1'b0;
			ws_r <= 2'h0;
			awrdy_r <= 1'b1;
			wrdy_r <= 1'b1;
			ardy_r <= 1'b1;
		end
		else
		begin
			awa_r <= awa_nxt;
			awh_r <= awh_nxt;
			wd_r <= wd_nxt;
			wh_r <= wh_nxt;
			bv_r <= bv_nxt;
			br_r <= br_nxt;
			rv_r <= rv_nxt;
			rd_r <= rd_nxt;
			rr_r <= rr_nxt;
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			is_rd_r <= is_rd_nxt;
			word_r <= word_nxt;
			rdat_r <= rdat_nxt;
			mode_r <= mode_nxt;
			ws_r <= ws_nxt;
			awrdy_r <= !awh_nxt;
			wrdy_r <= !wh_nxt;
			ardy_r <= !rv_nxt;
		end
	end

	assign s_axi_awready = awrdy_r;
	assign s_axi_wready = wrdy_r;
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = br_r;
	assign s_axi_arready = ardy_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rdata = rd_r;
	assign s_axi_rresp = rr_r;

	////////////////////////////////////////////////////////////////////////
	// pin drive, registered; data stays driven through the hold phase of a write

	logic strb;
	logic cs0n_r, cs1_r, wrn_r, rdn_r, doe_r;
	assign strb = st_nxt == ADCCR_H_STROBE;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cs0n_r <= 1'b1;
			cs1_r <= 1'b0;
			wrn_r <= 1'b1;
			rdn_r <= 1'b1;
			doe_r <= 1'b0;
		end
		else
		begin
			cs0n_r <= !strb;
			cs1_r <= strb;
			wrn_r <= !(strb && !is_rd_nxt) && !(mode_nxt && !is_rd_nxt && st_nxt != ADCCR_H_IDLE);
			rdn_r <= !(strb && is_rd_nxt && !mode_nxt);
			doe_r <= st_nxt != ADCCR_H_IDLE && !is_rd_nxt;
		end
	end

	assign bus.cs0_n = cs0n_r;
	assign bus.cs1 = cs1_r;
	assign bus.wr_n = wrn_r;
	assign bus.rd_n = rdn_r;
	assign bus.host_d = word_r;
	assign bus.host_d_oe = doe_r;

endmodule

// ### testbench/adccr_properties.sv
// assertions on the strobe port and the converter's control registers
`timescale 1ns/1ps
`include "adccr_cfg.svh"
module adccr_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cs0_n,
	input wire logic cs1,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic dev_d_oe,
	input wire logic [11:0] d,
	input wire logic sync_gen_reset,
	input wire logic [9:0] ctrl0_q,
	input wire logic [9:0] ctrl1_q
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic sel;
	logic oe_r;
	logic [1:0] rd_cnt_r;
	logic [1:0] rd_cnt_nxt;
	logic [3:0] idle_r;
	logic [3:0] idle_nxt;
	assign sel = !cs0_n && cs1;
	// idle_r: cycles since the last write strobe, so register changes can be tied to a write
	always_comb
	begin
		idle_nxt = (sel && !wr_n) ? 4'h0 : ((idle_r == 4'hF) ? idle_r : idle_r + 4'h1);
		rd_cnt_nxt = rd_cnt_r;
		if (!ctrl1_q[9])
			rd_cnt_nxt = 2'h0;
		else if (dev_d_oe && !oe_r && rd_cnt_r != 2'h3)
			rd_cnt_nxt = rd_cnt_r + 2'h1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			oe_r <= 1'b0;
			rd_cnt_r <= 2'h0;
			idle_r <= 4'hF;
		end
		else
		begin
			oe_r <= dev_d_oe;
			rd_cnt_r <= rd_cnt_nxt;
			idle_r <= idle_nxt;
		end
	end
	////////////////////////////////////////
	property p_rst_ctrl0; ctrl1_q[0] |-> ctrl0_q == `ADCCR_CTRL0_RST; endproperty
	a_rst_ctrl0: assert property (p_rst_ctrl0) else $error("ctrl0 not at default in reset");
	property p_rst_stay; $fell(ctrl1_q[0]) |-> idle_r < 4'h6; endproperty
	a_rst_stay: assert property (p_rst_stay) else $error("reset left without a write");
	property p_sync; sync_gen_reset |-> idle_r < 4'h6 ##1 !sync_gen_reset; endproperty
	a_sync: assert property (p_sync) else $error("sync reset pulse wrong");
	property p_sep_rd; sel && !ctrl1_q[6] && !rd_n && wr_n |=> dev_d_oe; endproperty
	a_sep_rd: assert property (p_sep_rd) else $error("separate read not answered");
	property p_comb_rd; sel && ctrl1_q[6] && wr_n |=> dev_d_oe; endproperty
	a_comb_rd: assert property (p_comb_rd) else $error("combined read not answered");
	property p_comb_wr; sel && ctrl1_q[6] && !wr_n ##1 sel && !wr_n |-> !dev_d_oe; endproperty
	a_comb_wr: assert property (p_comb_wr) else $error("device drives during write");
	property p_release; !sel ##1 !sel |-> !dev_d_oe; endproperty
	a_release: assert property (p_release) else $error("bus held while unselected");
	property p_dbg0; $rose(dev_d_oe) && ctrl1_q[9] && rd_cnt_r == 2'h0 |-> d == {2'b00, ctrl0_q}; endproperty
	a_dbg0: assert property (p_dbg0) else $error("first debug read wrong");
	property p_dbg1; $rose(dev_d_oe) && ctrl1_q[9] && rd_cnt_r == 2'h1 |-> d == {2'b01, ctrl1_q}; endproperty
	a_dbg1: assert property (p_dbg1) else $error("second debug read wrong");
	c_dbg: cover property ($rose(dev_d_oe) && ctrl1_q[9] && rd_cnt_r == 2'h1);
	c_comb: cover property (sel && ctrl1_q[6] && wr_n);
	c_rst: cover property ($fell(ctrl1_q[0]));
endmodule

// ### testbench/adccr_tb.sv
// self-checking bench: processor end and converter end joined over the strobe port
`timescale 1ns/1ps
`include "adccr_cfg.svh"
module adccr_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, cal_force_zero, result_valid, sync_gen_reset;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp, resp;
	logic sample_valid = 1'b0;
	logic [11:0] sample_code = 12'h000, result, e;
	logic [9:0] ctrl0_q, ctrl1_q;
	int errors = 0, n_tests = 0, n_sync = 0, got, c0, c1, off, fmt, m;
	adccr_if bus_if();
	adccr_host adccr_host_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus_if), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	adccr_dev adccr_dev_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus_if), .sample_valid(sample_valid),
		.sample_code(sample_code), .cal_force_zero(cal_force_zero), .result(result), .result_valid(result_valid),
		.sync_gen_reset(sync_gen_reset), .ctrl0_q(ctrl0_q), .ctrl1_q(ctrl1_q));
	adccr_properties adccr_properties_inst (.aclk(aclk), .aresetn(aresetn), .cs0_n(bus_if.cs0_n),
		.cs1(bus_if.cs1), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n), .dev_d_oe(bus_if.dev_d_oe), .d(bus_if.d),
		.sync_gen_reset(sync_gen_reset), .ctrl0_q(ctrl0_q), .ctrl1_q(ctrl1_q));
	always #5 aclk = ~aclk;
	always @(posedge aclk)
		if (sync_gen_reset === 1'b1)
			n_sync++;
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// the leading edge keeps two tasks from driving one signal in the same time step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] dt);
		@(posedge aclk);
		awaddr <= a;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic cmd(input logic [7:0] a, input int dt);
		axi_wr(a, dt);
		do
			axi_rd(`ADCCR_A_STAT);
		while (v[0] !== 1'b0);
	endtask
	task automatic dev_read;
		cmd(`ADCCR_A_READ, 0);
		axi_rd(`ADCCR_A_RDATA);
	endtask
	task automatic samp(input int code);
		@(posedge aclk);
		sample_code <= code[11:0];
		sample_valid <= 1'b1;
		@(posedge aclk);
		sample_valid <= 1'b0;
		got = 0;
		repeat (8)
		begin
			@(posedge aclk);
			if (result_valid === 1'b1)
			begin
				got = 1;
				break;
			end
		end
	endtask
	task automatic samp_chk(input int code);
		samp(code);
		e = code[11:0] - off[11:0];
		if (fmt != 0)
			e[11] = ~e[11];
		check(got, 1);
		check(result, e);
	endtask
	////////////////////////////////////////
	initial
	begin
		void'($urandom(32'h21B4));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		check(ctrl0_q, `ADCCR_CTRL0_RST);
		check(ctrl1_q, `ADCCR_CTRL1_RST);
		c0 = $urandom % 1024;
		cmd(`ADCCR_A_CTRL0, c0);
		check(ctrl0_q, c0);
		check(ctrl1_q, `ADCCR_CTRL1_RST);
		cmd(`ADCCR_A_CTRL1, 32'h03E);
		check(ctrl1_q, 10'h002);
		check(n_sync, 1);
		cmd(`ADCCR_A_CTRL1, 32'h001);
		check(ctrl0_q, `ADCCR_CTRL0_RST);
		check(ctrl1_q, 10'h031);
		samp(12'h155);
		check(got, 0);
		cmd(`ADCCR_A_CTRL0, 32'h3FF);
		check(ctrl0_q, `ADCCR_CTRL0_RST);
		cmd(`ADCCR_A_CTRL1, 32'h000);
		check(ctrl1_q, 10'h000);
		c0 = `ADCCR_CTRL0_RST;
		off = $urandom % 64;
		fmt = 0;
		cmd(`ADCCR_A_CTRL1, 32'h100);
		check(cal_force_zero, 1'b1);
		samp(off);
		check(got, 0);
		check(cal_force_zero, 1'b0);
		for (fmt = 0; fmt < 2; fmt++)
		begin
			cmd(`ADCCR_A_CTRL1, fmt << 7);
			repeat (3)
				samp_chk($urandom);
		end
		fmt = 0;
		// second pass runs the debug reads with the direction input in combined mode
		for (m = 0; m < 2; m++)
		begin
			c1 = 32'h200 | (m << 6);
			cmd(`ADCCR_A_CTRL1, c1);
			axi_rd(`ADCCR_A_STAT);
			check(v[1], m[0]);
			dev_read;
			check(v, {2'b00, c0[9:0]});
			dev_read;
			check(v, {2'b01, c1[9:0]});
			samp_chk($urandom);
			dev_read;
			check(v, e);
			cmd(`ADCCR_A_CTRL1, m << 6);
			check(ctrl1_q, m << 6);
		end
		// a control write without both low byte strobes must leave the register alone
		wstrb <= 4'h1;
		cmd(`ADCCR_A_CTRL0, 32'h155);
		check(ctrl0_q, `ADCCR_CTRL0_RST);
		wstrb <= 4'hF;
		axi_rd(8'h14);
		check(resp, `ADCCR_RESP_SLVERR);
		axi_wr(8'h14, 0);
		check(resp, `ADCCR_RESP_SLVERR);
		complete_run;
	end
	initial
	begin
		#200us;
		errors++;
		complete_run;
	end
endmodule
